// ### high_voltage_io_ports_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin mismatches++; $display("ERROR %s exp %0h got %0h", nm, ex, gt); end end
module high_voltage_io_ports_tb;
  logic        ref_clk, reset, avs_read, avs_write, avs_waitrequest, key_scan_active, p4_ext_en;
  logic        irq_pin_pullup_en, p3_pulldown_en, p4_pulldown_en;
  logic [17:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable, seg_drive_data, p3_pin_in, p3_pin_out, p3_pin_oe, seg_pin_owned;
  logic [2:0]  op_mode;
  logic [6:0]  irq_port_out_req, irq_port_oe_req, irq_pin_out, irq_pin_oe;
  logic [7:0]  p4_pin_in, p4_pin_out, p4_pin_oe, p4_ext;
  int          mismatches, compares;

  hvio_ports uut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .op_mode(op_mode),
    .key_scan_active(key_scan_active), .seg_drive_data(seg_drive_data), .irq_port_out_req(irq_port_out_req),
    .irq_port_oe_req(irq_port_oe_req), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
    .irq_pin_pullup_en(irq_pin_pullup_en), .p3_pin_in(p3_pin_in), .p3_pin_out(p3_pin_out),
    .p3_pin_oe(p3_pin_oe), .p3_pulldown_en(p3_pulldown_en), .p4_pin_in(p4_pin_in), .p4_pin_out(p4_pin_out),
    .p4_pin_oe(p4_pin_oe), .p4_pulldown_en(p4_pulldown_en), .seg_pin_owned(seg_pin_owned));

  hvio_pin_model pins (.ref_clk(ref_clk), .p3_pin_out(p3_pin_out), .p3_pin_oe(p3_pin_oe),
    .p3_pulldown_en(p3_pulldown_en), .p4_pin_out(p4_pin_out), .p4_pin_oe(p4_pin_oe),
    .p4_pulldown_en(p4_pulldown_en), .p4_ext(p4_ext), .p4_ext_en(p4_ext_en), .p3_pin_in(p3_pin_in),
    .p4_pin_in(p4_pin_in));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // =====================================================================
  // avalon master: hold until waitrequest seen low, then release
  task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write     <= w;
    avs_read      <= ~w;
    #1;
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 20) begin
        mismatches++;
        end_sim();
      end
    end
    @(posedge ref_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle

  // =====================================================================
  // scenarios
  task automatic t_regs();
    bus(hvio_pkg::IDX_P3_DATA, 1'b0, 8'h00); `CHK("p3 reset", 8'hF0, rd[7:0])
    bus(hvio_pkg::IDX_P4_DATA, 1'b0, 8'h00); `CHK("p4 reset", 8'h00, rd[7:0])
    bus(hvio_pkg::IDX_P3_DATA, 1'b1, 8'h0A);
    bus(hvio_pkg::IDX_P3_DATA, 1'b0, 8'h00); `CHK("p3 rw", 8'hFA, rd[7:0])
    bus(hvio_pkg::IDX_P3_DATA, 1'b1, 8'h05);
    bus(hvio_pkg::IDX_P3_DATA, 1'b0, 8'h00); `CHK("p3 rsvd", 8'hF5, rd[7:0])
    bus(hvio_pkg::IDX_P4_DATA, 1'b1, 8'hA5);
    bus(hvio_pkg::IDX_P4_DATA, 1'b0, 8'h00); `CHK("p4 rw", 8'hA5, rd[7:0])
    bus(16'hFFE0, 1'b1, 8'hFF);
    bus(16'hFFE0, 1'b0, 8'h00); `CHK("unmapped", 32'h00000000, rd)
  endtask : t_regs

  task automatic t_pins();
    bus(hvio_pkg::IDX_P3_DIR, 1'b1, 8'h0F);
    bus(hvio_pkg::IDX_P4_DIR, 1'b1, 8'hF0);
    settle();
    `CHK("p3 out", 4'h5, p3_pin_out)
    `CHK("p3 oe", 4'hF, p3_pin_oe)
    `CHK("p4 oe", 8'hF0, p4_pin_oe)
    `CHK("p4 out", 4'hA, p4_pin_out[7:4])
    `CHK("irq oe", 7'h7F, irq_pin_oe)
    `CHK("irq out", 7'h55, irq_pin_out)
    bus(hvio_pkg::IDX_P4_PINS, 1'b0, 8'h00); `CHK("p4 pins", 8'hAC, rd[7:0])
    bus(hvio_pkg::IDX_P3_PINS, 1'b0, 8'h00); `CHK("p3 pins", 4'h5, rd[3:0])
  endtask : t_pins

  task automatic t_seg();
    bus(hvio_pkg::IDX_SEG_CTRL, 1'b1, 8'h19);
    #1; `CHK("range only", 4'h0, seg_pin_owned)
    bus(hvio_pkg::IDX_SEG_CTRL, 1'b1, 8'h99);
    #1; `CHK("range 25", 4'h3, seg_pin_owned)
    @(posedge ref_clk); #1; `CHK("seg out", 4'h6, p3_pin_out)
    @(posedge ref_clk);
    key_scan_active <= 1'b1;
    @(posedge ref_clk); #1; `CHK("key scan", 4'h0, seg_pin_owned)
    `CHK("key scan pins", 4'h5, p3_pin_out)
    @(posedge ref_clk);
    key_scan_active <= 1'b0;
    bus(hvio_pkg::IDX_SEG_CTRL, 1'b1, 8'h9B);
    #1; `CHK("range 27", 4'hF, seg_pin_owned)
    bus(hvio_pkg::IDX_SEG_CTRL, 1'b1, 8'h1B);
    #1; `CHK("flag off", 4'h0, seg_pin_owned)
  endtask : t_seg

  task automatic t_modes();
    // codes 5 to 7 are illegal and must park like standby
    for (int m = 2; m <= 7; m++) begin
      @(posedge ref_clk);
      op_mode <= m[2:0];
      settle();
      `CHK("p3 oe low", 4'h0, p3_pin_oe)
      `CHK("p3 pull", 1'b1, p3_pulldown_en)
      `CHK("p4 oe low", 8'h00, p4_pin_oe)
      `CHK("p4 pull", 1'b1, p4_pulldown_en)
      `CHK("irq oe low", 7'h00, irq_pin_oe)
      `CHK("irq pull", 1'b0, irq_pin_pullup_en)
    end
    // sleep is entered from active, so it must retain the active drive
    @(posedge ref_clk);
    op_mode <= 3'h0;
    settle();
    @(posedge ref_clk);
    op_mode <= 3'h1;
    bus(hvio_pkg::IDX_P3_DATA, 1'b1, 8'h0A);
    settle(); `CHK("sleep hold", 4'h5, p3_pin_out)
    `CHK("sleep p3 oe", 4'hF, p3_pin_oe)
    `CHK("sleep irq", 7'h7F, irq_pin_oe)
    @(posedge ref_clk);
    op_mode <= 3'h0;
    settle(); `CHK("active", 4'hA, p3_pin_out)
  endtask : t_modes

  task automatic t_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("mid rst p3 oe", 4'h0, p3_pin_oe)
    `CHK("mid rst irq pull", 1'b1, irq_pin_pullup_en)
    @(posedge ref_clk);
    reset <= 1'b0;
    bus(hvio_pkg::IDX_P3_DATA, 1'b0, 8'h00); `CHK("p3 re-reset", 8'hF0, rd[7:0])
    bus(hvio_pkg::IDX_P4_DATA, 1'b0, 8'h00); `CHK("p4 re-reset", 8'h00, rd[7:0])
  endtask : t_reset

  initial begin
    reset = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = '0; avs_writedata = '0;
    avs_byteenable = 4'hF; op_mode = 3'h0; key_scan_active = 1'b0; seg_drive_data = 4'h6;
    irq_port_out_req = 7'h55; irq_port_oe_req = 7'h7F; p4_ext = 8'h3C; p4_ext_en = 1'b1;
    mismatches = 0; compares = 0;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK("rst p3 oe", 4'h0, p3_pin_oe)
    `CHK("rst p3 pull", 1'b1, p3_pulldown_en)
    `CHK("rst irq pull", 1'b1, irq_pin_pullup_en)
    `CHK("rst irq oe", 7'h00, irq_pin_oe)
    @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_pins();
    t_seg();
    t_modes();
    t_reset();
    end_sim();
  end
endmodule : high_voltage_io_ports_tb

// ### hvio_pin_model.sv
`timescale 1ns/1ps
// =====================================================================
// external pins: resolve each pad from device drive, board drive (port 4 only), pull
module hvio_pin_model (
  input  wire logic       ref_clk,
  input  wire logic [3:0] p3_pin_out,
  input  wire logic [3:0] p3_pin_oe,
  input  wire logic       p3_pulldown_en,
  input  wire logic [7:0] p4_pin_out,
  input  wire logic [7:0] p4_pin_oe,
  input  wire logic       p4_pulldown_en,
  input  wire logic [7:0] p4_ext,
  input  wire logic       p4_ext_en,
  output logic      [3:0] p3_pin_in,
  output logic      [7:0] p4_pin_in
);
  logic [3:0] p3_last_q;
  logic [7:0] p4_last_q;

  // floating pads toggle so a stale level never passes for a driven one
  always_ff @(posedge ref_clk) begin
    p3_last_q <= p3_pin_in;
    p4_last_q <= p4_pin_in;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      p3_pin_in[i] = p3_pin_oe[i] ? p3_pin_out[i] : (p3_pulldown_en ? 1'b0 : ~p3_last_q[i]);
    end
    for (int i = 0; i < 8; i++) begin
      p4_pin_in[i] = p4_pin_oe[i] ? p4_pin_out[i] : (p4_ext_en ? p4_ext[i] :
                     (p4_pulldown_en ? 1'b0 : ~p4_last_q[i]));
    end
  end
endmodule : hvio_pin_model

// ### hvio_pkg.sv
package hvio_pkg;

  // =====================================================================
  // bus geometry
  localparam int unsigned ADDR_W      = 18;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned IDX_W       = 16;

  // =====================================================================
  // register indices (byte address = 4 * index)
  localparam logic [IDX_W-1:0] IDX_SEG_CTRL   = 16'hFFD0;
  localparam logic [IDX_W-1:0] IDX_P3_DATA    = 16'hFFD3;
  localparam logic [IDX_W-1:0] IDX_P4_DATA    = 16'hFFD4;
  localparam logic [IDX_W-1:0] IDX_P3_DIR     = 16'hFFD6;
  localparam logic [IDX_W-1:0] IDX_P4_DIR     = 16'hFFD7;
  localparam logic [IDX_W-1:0] IDX_P3_PINS    = 16'hFFD8;
  localparam logic [IDX_W-1:0] IDX_P4_PINS    = 16'hFFD9;

  // =====================================================================
  // widths, fields and reset values
  localparam int unsigned P1_W        = 7;
  localparam int unsigned P3_W        = 4;
  localparam int unsigned P4_W        = 8;
  localparam int unsigned RANGE_W     = 5;
  localparam int unsigned SEG_FLAG_BIT = 7;
  localparam logic [3:0]  P3_RSVD_ONES = 4'hF;
  localparam logic [7:0]  P3_RESET    = 8'hF0;
  localparam logic [7:0]  P4_RESET    = 8'h00;
  // first segment number carried on port 3 pin 0
  localparam logic [RANGE_W-1:0] SEG_BASE = 5'h18;

  // =====================================================================
  // operating modes, driven by the power-down controller
  typedef enum logic [2:0] {
    MODE_ACTIVE    = 3'b000,
    MODE_SLEEP     = 3'b001,
    MODE_STANDBY   = 3'b010,
    MODE_WATCH     = 3'b011,
    MODE_SUBACTIVE = 3'b100
  } hvio_mode_t;

endpackage : hvio_pkg

// ### hvio_ports.sv
`timescale 1ns/1ps
module hvio_ports #(
  parameter int unsigned P3_PINS = hvio_pkg::P3_W,
  parameter int unsigned P4_PINS = hvio_pkg::P4_W
) (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  // avalon-mm slave
  input  wire logic [hvio_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [hvio_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [hvio_pkg::DATA_W-1:0]   avs_readdata,
  output logic                               avs_waitrequest,
  // system side, same clock
  input  wire logic [2:0]                    op_mode,
  input  wire logic                          key_scan_active,
  input  wire logic [P3_PINS-1:0]            seg_drive_data,
  input  wire logic [hvio_pkg::P1_W-1:0]     irq_port_out_req,
  input  wire logic [hvio_pkg::P1_W-1:0]     irq_port_oe_req,
  // interrupt/event shared pins
  output logic      [hvio_pkg::P1_W-1:0]     irq_pin_out,
  output logic      [hvio_pkg::P1_W-1:0]     irq_pin_oe,
  output logic                               irq_pin_pullup_en,
  // segment-shared port
  input  wire logic [P3_PINS-1:0]            p3_pin_in,
  output logic      [P3_PINS-1:0]            p3_pin_out,
  output logic      [P3_PINS-1:0]            p3_pin_oe,
  output logic                               p3_pulldown_en,
  // eight-pin port
  input  wire logic [P4_PINS-1:0]            p4_pin_in,
  output logic      [P4_PINS-1:0]            p4_pin_out,
  output logic      [P4_PINS-1:0]            p4_pin_oe,
  output logic                               p4_pulldown_en,
  output logic      [P3_PINS-1:0]            seg_pin_owned
);

  // =====================================================================
  // state
  typedef struct packed {
    logic [P3_PINS-1:0]              p3_data;
    logic [P4_PINS-1:0]              p4_data;
    logic [P3_PINS-1:0]              p3_dir;
    logic [P4_PINS-1:0]              p4_dir;
    logic                            seg_flag;
    logic [hvio_pkg::RANGE_W-1:0]    seg_range;
    logic                            ack;
    logic [hvio_pkg::DATA_W-1:0]     rdata;
    logic [hvio_pkg::P1_W-1:0]       p1_out;
    logic [hvio_pkg::P1_W-1:0]       p1_oe;
    logic                            p1_pu;
    logic [P3_PINS-1:0]              p3_out;
    logic [P3_PINS-1:0]              p3_oe;
    logic                            p3_pd;
    logic [P4_PINS-1:0]              p4_out;
    logic [P4_PINS-1:0]              p4_oe;
    logic                            p4_pd;
    logic [P3_PINS-1:0]              p3_sync1;
    logic [P3_PINS-1:0]              p3_sync2;
    logic [P4_PINS-1:0]              p4_sync1;
    logic [P4_PINS-1:0]              p4_sync2;
  } hvio_state_t;

  hvio_state_t                  st_q;
  hvio_state_t                  st_d;
  logic [hvio_pkg::IDX_W-1:0]   reg_idx;
  logic [P3_PINS-1:0]           seg_own;
  hvio_pkg::hvio_mode_t         mode;

  assign reg_idx = avs_address[hvio_pkg::ADDR_W-1:2];
  assign mode    = hvio_pkg::hvio_mode_t'(op_mode);

  // =====================================================================
  // segment ownership per pin
  // key scan hands pins back to the port so keys can be polled
  genvar gi;
  generate
    for (gi = 0; gi < P3_PINS; gi++) begin : g_seg
      localparam logic [hvio_pkg::RANGE_W-1:0] SEG_NUM = hvio_pkg::SEG_BASE + hvio_pkg::RANGE_W'(gi);
      assign seg_own[gi] = st_q.seg_flag && (st_q.seg_range >= SEG_NUM) && !key_scan_active;
    end
  endgenerate

  // =====================================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.p3_sync1 = p3_pin_in;
    st_d.p3_sync2 = st_q.p3_sync1;
    st_d.p4_sync1 = p4_pin_in;
    st_d.p4_sync2 = st_q.p4_sync1;

    // one wait cycle, then the answer: data is registered at the accept edge
    st_d.ack = 1'b0;
    if ((avs_read || avs_write) && !st_q.ack) begin
      st_d.ack   = 1'b1;
      st_d.rdata = '0;
      if (avs_read) begin
        unique case (reg_idx)
          hvio_pkg::IDX_SEG_CTRL: begin
            st_d.rdata[hvio_pkg::SEG_FLAG_BIT]      = st_q.seg_flag;
            st_d.rdata[hvio_pkg::RANGE_W-1:0]       = st_q.seg_range;
          end
          hvio_pkg::IDX_P3_DATA: begin
            st_d.rdata[7:0] = {hvio_pkg::P3_RSVD_ONES, st_q.p3_data};
          end
          hvio_pkg::IDX_P4_DATA: begin
            st_d.rdata[P4_PINS-1:0] = st_q.p4_data;
          end
          hvio_pkg::IDX_P3_DIR: begin
            st_d.rdata[P3_PINS-1:0] = st_q.p3_dir;
          end
          hvio_pkg::IDX_P4_DIR: begin
            st_d.rdata[P4_PINS-1:0] = st_q.p4_dir;
          end
          hvio_pkg::IDX_P3_PINS: begin
            st_d.rdata[P3_PINS-1:0] = st_q.p3_sync2;
          end
          hvio_pkg::IDX_P4_PINS: begin
            st_d.rdata[P4_PINS-1:0] = st_q.p4_sync2;
          end
          default: begin
            st_d.rdata = '0;
          end
        endcase
      end
    end

    // writes land on the edge that completes the transfer
    if (st_q.ack && avs_write && avs_byteenable[0]) begin
      unique case (reg_idx)
        hvio_pkg::IDX_SEG_CTRL: begin
          st_d.seg_flag  = avs_writedata[hvio_pkg::SEG_FLAG_BIT];
          st_d.seg_range = avs_writedata[hvio_pkg::RANGE_W-1:0];
        end
        hvio_pkg::IDX_P3_DATA: begin
          st_d.p3_data = avs_writedata[P3_PINS-1:0];
        end
        hvio_pkg::IDX_P4_DATA: begin
          st_d.p4_data = avs_writedata[P4_PINS-1:0];
        end
        hvio_pkg::IDX_P3_DIR: begin
          st_d.p3_dir = avs_writedata[P3_PINS-1:0];
        end
        hvio_pkg::IDX_P4_DIR: begin
          st_d.p4_dir = avs_writedata[P4_PINS-1:0];
        end
        default: begin
        end
      endcase
    end

    // pin drive per operating mode
    unique case (mode)
      hvio_pkg::MODE_ACTIVE: begin
        st_d.p1_out = irq_port_out_req;
        st_d.p1_oe  = irq_port_oe_req;
        st_d.p1_pu  = 1'b0;
        for (int i = 0; i < P3_PINS; i++) begin
          st_d.p3_out[i] = seg_own[i] ? seg_drive_data[i] : st_q.p3_data[i];
          st_d.p3_oe[i]  = seg_own[i] | st_q.p3_dir[i];
        end
        st_d.p3_pd  = 1'b0;
        st_d.p4_out = st_q.p4_data;
        st_d.p4_oe  = st_q.p4_dir;
        st_d.p4_pd  = 1'b0;
      end
      hvio_pkg::MODE_SLEEP: begin
        // hold everything as it stood on entry
        // segment data freezes too, so the display stalls while asleep
        st_d.p1_out = st_q.p1_out;
      end
      hvio_pkg::MODE_STANDBY, hvio_pkg::MODE_WATCH, hvio_pkg::MODE_SUBACTIVE: begin
        st_d.p1_oe  = '0;
        st_d.p1_pu  = 1'b0;
        st_d.p3_oe  = '0;
        st_d.p3_pd  = 1'b1;
        st_d.p4_oe  = '0;
        st_d.p4_pd  = 1'b1;
      end
      default: begin
        // illegal mode codes park the pins safely
        st_d.p1_oe  = '0;
        st_d.p1_pu  = 1'b0;
        st_d.p3_oe  = '0;
        st_d.p3_pd  = 1'b1;
        st_d.p4_oe  = '0;
        st_d.p4_pd  = 1'b1;
      end
    endcase
  end

  // =====================================================================
  // registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_q           <= '0;
      st_q.p3_data   <= hvio_pkg::P3_RESET[P3_PINS-1:0];
      st_q.p4_data   <= hvio_pkg::P4_RESET[P4_PINS-1:0];
      st_q.p1_pu     <= 1'b1;
      st_q.p3_pd     <= 1'b1;
      st_q.p4_pd     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // =====================================================================
  // outputs
  // two cycles per access: readdata comes from a flop, not from the decoder
  assign avs_waitrequest   = (avs_read || avs_write) && !st_q.ack;
  assign avs_readdata      = st_q.rdata;
  assign irq_pin_out       = st_q.p1_out;
  assign irq_pin_oe        = st_q.p1_oe;
  assign irq_pin_pullup_en = st_q.p1_pu;
  assign p3_pin_out        = st_q.p3_out;
  assign p3_pin_oe         = st_q.p3_oe;
  assign p3_pulldown_en    = st_q.p3_pd;
  assign p4_pin_out        = st_q.p4_out;
  assign p4_pin_oe         = st_q.p4_oe;
  assign p4_pulldown_en    = st_q.p4_pd;
  assign seg_pin_owned     = seg_own;

  // =====================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_p3_reset;
    $past(reset) |-> (st_q.p3_data == '0) && p3_pulldown_en && (p3_pin_oe == '0);
  endproperty
  a_p3_reset: assert property (p_p3_reset) else $error("port 3 not at reset state");

  property p_p4_reset;
    $past(reset) |-> (st_q.p4_data == hvio_pkg::P4_RESET[P4_PINS-1:0]);
  endproperty
  a_p4_reset: assert property (p_p4_reset) else $error("port 4 data not cleared");

  property p_p3_read_rsvd;
    (avs_read && st_q.ack && reg_idx == hvio_pkg::IDX_P3_DATA)
      |-> (avs_readdata[7:4] == hvio_pkg::P3_RSVD_ONES) && (avs_readdata[3:0] == st_q.p3_data);
  endproperty
  a_p3_read_rsvd: assert property (p_p3_read_rsvd) else $error("port 3 read wrong");

  property p_p3_write;
    (avs_write && st_q.ack && avs_byteenable[0] && reg_idx == hvio_pkg::IDX_P3_DATA)
      |=> (st_q.p3_data == $past(avs_writedata[P3_PINS-1:0]));
  endproperty
  a_p3_write: assert property (p_p3_write) else $error("port 3 write lost");

  property p_p4_write;
    (avs_write && st_q.ack && avs_byteenable[0] && reg_idx == hvio_pkg::IDX_P4_DATA)
      |=> ##1 (mode != hvio_pkg::MODE_ACTIVE || p4_pin_out == $past(avs_writedata[P4_PINS-1:0], 2));
  endproperty
  a_p4_write: assert property (p_p4_write) else $error("port 4 write not on pins");

  property p_flag_clear;
    (avs_write && st_q.ack && avs_byteenable[0] && reg_idx == hvio_pkg::IDX_SEG_CTRL
      && !avs_writedata[hvio_pkg::SEG_FLAG_BIT]) |=> (seg_pin_owned == '0);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("segment pins kept after flag clear");

  property p_key_scan;
    (mode == hvio_pkg::MODE_ACTIVE && key_scan_active)
      |=> (p3_pin_out == $past(st_q.p3_data));
  endproperty
  a_key_scan: assert property (p_key_scan) else $error("port data not on pins in key scan");

  property p_seg_drive;
    (mode == hvio_pkg::MODE_ACTIVE && seg_pin_owned[0])
      |=> p3_pin_oe[0] && (p3_pin_out[0] == $past(seg_drive_data[0]));
  endproperty
  a_seg_drive: assert property (p_seg_drive) else $error("segment pin not driven");

  property p_p3_lowpower;
    (mode == hvio_pkg::MODE_STANDBY || mode == hvio_pkg::MODE_WATCH || mode == hvio_pkg::MODE_SUBACTIVE)
      |=> (p3_pin_oe == '0) && p3_pulldown_en;
  endproperty
  a_p3_lowpower: assert property (p_p3_lowpower) else $error("port 3 driven in low power");

  property p_irq_sleep;
    (mode == hvio_pkg::MODE_SLEEP) |=> $stable(irq_pin_out) && $stable(irq_pin_oe) && $stable(p3_pin_out);
  endproperty
  a_irq_sleep: assert property (p_irq_sleep) else $error("pins changed in sleep");

endmodule : hvio_ports
